// [rtl/audio_pwm_output.sv]
// Audio PWM/DAC output block with nibble registers and request interrupt
//
// Contract
// - Sample top bit is the sign
// - DAC option reroutes sample to DAC output
// - Resolution follows ten and twelve options
// - 8-bit sample uses low and high nibble
// - One PWM cycle per 32 kHz period
// - 10-bit sample takes extra-low upper two bits
// - 12-bit sample takes all three nibbles
// - 10-bit magnitude spans 0 to 511
// - 12-bit magnitude spans 0 to 2047
// - Period end sets request flag status bit 2
// - Double buffer loads at period end
// - No new write reuses previous sample
// - Enable bit gates output; disabled drives low
// - Halt clears enable and floats speaker pins
// - Enabled request taken next clock, clears enable
//
// Overview
// Software stages a sample in three write-only nibbles. At each period end
// the staged nibbles move to the active stage, the request flag and the
// period-end event bit rise, and the counter wraps, so exactly one sample
// plays per period however late software is.
//
// The leg that pulses follows the sign of the active sample; the other leg
// stays low. A pulse starts at count zero and lasts magnitude clocks, so
// large 12-bit magnitudes clip at the period length.
//
// In converter mode the legs stay low and the same active sample is shown
// as a parallel code with a valid level.
//
// Halt drops the enable and lets the pins float until the next control
// write; a control write in the same cycle as halt loses to it.
//
// Interrupts: the period-end and acceptance events set sticky bits that a
// written one clears; a new event in the clearing cycle wins. IRQ is the
// registered OR of the unmasked bits. Acceptance needs the global enable
// and the request flag, pulses one clock later and drops the enable.
//
// The build options live in a register so one netlist covers every
// variant; software sets them once before enabling the output.
// Sample nibbles are write-only and read back as zero.
// The status read also shows the core carry and zero flags.
//
// Reset clears every register except the pin enable, which it sets, so the pins are driven low.
`timescale 1ns/1ps
`include "audio_pwm_defines.svh"

module audio_pwm_output (
   // Clock and reset
   input  wire logic                CORE_CLK,
   input  wire logic                RESET,
   // Register port
   input  wire logic [`ADDR_W-1:0]  ADDR,
   input  wire logic [`DATA_W-1:0]  WDATA,
   input  wire logic                WR,
   input  wire logic                RD,
   output logic      [`DATA_W-1:0]  RDATA,
   // Core events
   input  wire logic                HALT_EXEC,
   input  wire logic                CARRY_IN,
   input  wire logic                ZERO_IN,
   // Speaker pins
   output logic                     SPEAKER_OUT_POSITIVE,
   output logic                     SPEAKER_OUT_NEGATIVE,
   output logic                     SPEAKER_OE,
   // DAC
   output logic                     DAC_VALID,
   output logic      [11:0]         DAC_CODE,
   // Interrupt
   output logic                     INT_ACCEPT,
   output logic                     IRQ
);
   ////////////////////////////////////////////////////////////////////////////////
   // Decode helpers
   function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   function automatic audio_pwm_pkg::resolution_e pick_res(input logic ten,
                                                            input logic twelve);
      if (twelve) begin
         pick_res = audio_pwm_pkg::RES_12;
      end else if (ten) begin
         pick_res = audio_pwm_pkg::RES_10;
      end else begin
         pick_res = audio_pwm_pkg::RES_8;
      end
   endfunction : pick_res

   // Pulse is high while the count is below the magnitude; both sides are
   // widened so the compare stays unsigned
   function automatic logic pulse_on(input logic [`PERIOD_W-1:0] cnt,
                                     input logic [10:0]           mag);
      pulse_on = ({1'b0, cnt} < {1'b0, mag});
   endfunction : pulse_on

   // Sticky bit: a new event beats a write-one clear in the same cycle
   function automatic logic sticky_next(input logic cur,
                                        input logic set,
                                        input logic clr);
      sticky_next = set || (cur && !clr);
   endfunction : sticky_next

   ////////////////////////////////////////////////////////////////////////////////
   // Register map: status 0x00, extra-low 0x08, control 0x09, low 0x0a,
   // high 0x0b, options 0x10, event status 0x11, event mask 0x12
   logic                        wr_status;
   logic                        wr_control;
   logic                        wr_irq_status;
   logic [3:0]                  extra_low_reg;
   logic [3:0]                  low_reg;
   logic [3:0]                  high_reg;
   logic [3:0]                  active_extra_reg;
   logic [3:0]                  active_low_reg;
   logic [3:0]                  active_high_reg;
   logic [2:0]                  options_reg;
   logic                        output_enable_reg;
   logic                        global_ie_reg;
   logic                        request_flag_reg;
   logic                        halted_reg;
   logic [1:0]                  irq_status_reg;
   logic [1:0]                  irq_mask_reg;
   logic                        accept_now;
   audio_pwm_pkg::resolution_e  res;
   logic                        negative;
   logic [10:0]                 magnitude;
   logic [`PERIOD_W-1:0]        count;
   logic                        period_end;
   logic                        dac_active;
   logic                        leg_on;

   assign wr_status     = WR && hit(ADDR, `OFS_STATUS);
   assign wr_control    = WR && hit(ADDR, `OFS_CONTROL);
   assign wr_irq_status = WR && hit(ADDR, `OFS_IRQ_STATUS);
   assign res           = pick_res(options_reg[`BIT_OPT_TEN], options_reg[`BIT_OPT_TWELVE]);
   assign accept_now    = global_ie_reg && request_flag_reg;
   // Converter mode and pulse window, each shared by two consumers
   assign dac_active    = output_enable_reg && options_reg[`BIT_OPT_DAC];
   assign leg_on        = pulse_on(count, magnitude);

   ////////////////////////////////////////////////////////////////////////////////
   // Write-only sample staging registers; held until software rewrites them
   // One nibble per strobe; unmapped offsets change nothing
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         extra_low_reg <= `NIBBLE_ZERO;
         low_reg       <= `NIBBLE_ZERO;
         high_reg      <= `NIBBLE_ZERO;
      end else if (WR) begin
         if (hit(ADDR, `OFS_EXTRA_LOW)) begin
            extra_low_reg <= WDATA;
         end else if (hit(ADDR, `OFS_LOW)) begin
            low_reg <= WDATA;
         end else if (hit(ADDR, `OFS_HIGH)) begin
            high_reg <= WDATA;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Active stage: loads only at period end, so a missing write replays the old one
   // All three nibbles move together; a half-written sample plays only if period end falls between its writes
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         active_extra_reg <= `NIBBLE_ZERO;
         active_low_reg   <= `NIBBLE_ZERO;
         active_high_reg  <= `NIBBLE_ZERO;
      end else if (period_end) begin
         active_extra_reg <= extra_low_reg;
         active_low_reg   <= low_reg;
         active_high_reg  <= high_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Build options, fixed by software at set-up in place of fuses
   // Changing them while enabled takes effect at once and may click
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         options_reg <= 3'b000;
      end else if (WR && hit(ADDR, `OFS_OPTIONS)) begin
         options_reg <= WDATA[2:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Control: halt wins over software, acceptance clears the global enable
   // Both enables sit in one register but have separate owners
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         output_enable_reg <= 1'b0;
         global_ie_reg     <= 1'b0;
         halted_reg        <= 1'b0;
      end else begin
         if (HALT_EXEC) begin
            output_enable_reg <= 1'b0;
            halted_reg        <= 1'b1;
         end else if (wr_control) begin
            output_enable_reg <= WDATA[`BIT_OUTPUT_ENABLE];
            halted_reg        <= 1'b0;
         end
         if (accept_now) begin
            global_ie_reg <= 1'b0;
         end else if (wr_control) begin
            global_ie_reg <= WDATA[`BIT_GLOBAL_IE];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Request flag: set at period end wins over a software clear; entry leaves it
   // Software owns the clear, hardware never clears it on acceptance
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         request_flag_reg <= 1'b0;
      end else if (period_end) begin
         request_flag_reg <= 1'b1;
      end else if (wr_status) begin
         request_flag_reg <= WDATA[`BIT_REQUEST_FLAG];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt acceptance strobe, one clock after the enabled request
   // Registered so the strobe is clean; the global enable drops with it
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         INT_ACCEPT <= 1'b0;
      end else begin
         INT_ACCEPT <= accept_now;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sticky event bits, write one to clear; a new event beats the clear
   // IRQ is registered, so it trails the status bit by one clock
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         irq_status_reg <= 2'b00;
         irq_mask_reg   <= 2'b00;
         IRQ            <= 1'b0;
      end else begin
         irq_status_reg[`IRQ_BIT_REQUEST] <= sticky_next(irq_status_reg[`IRQ_BIT_REQUEST],
            period_end, wr_irq_status && WDATA[`IRQ_BIT_REQUEST]);
         irq_status_reg[`IRQ_BIT_ACCEPT] <= sticky_next(irq_status_reg[`IRQ_BIT_ACCEPT],
            accept_now, wr_irq_status && WDATA[`IRQ_BIT_ACCEPT]);
         if (WR && hit(ADDR, `OFS_IRQ_MASK)) begin
            irq_mask_reg <= WDATA[1:0];
         end
         IRQ <= |(irq_status_reg & irq_mask_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read port; sample registers are write-only and read as zero
   // Unmapped offsets and idle cycles return zero, never a stale value
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         RDATA <= `NIBBLE_ZERO;
      end else if (RD) begin
         if (hit(ADDR, `OFS_STATUS)) begin
            RDATA <= {1'b0, request_flag_reg, CARRY_IN, ZERO_IN};
         end else if (hit(ADDR, `OFS_CONTROL)) begin
            RDATA <= {2'b00, global_ie_reg, output_enable_reg};
         end else if (hit(ADDR, `OFS_OPTIONS)) begin
            RDATA <= {1'b0, options_reg};
         end else if (hit(ADDR, `OFS_IRQ_STATUS)) begin
            RDATA <= {2'b00, irq_status_reg};
         end else if (hit(ADDR, `OFS_IRQ_MASK)) begin
            RDATA <= {2'b00, irq_mask_reg};
         end else begin
            RDATA <= `NIBBLE_ZERO;
         end
      end else begin
         RDATA <= `NIBBLE_ZERO;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sub-blocks
   // The timer runs only while enabled, so a fresh enable starts a whole period
   period_timer u_timer (
      .clk        (CORE_CLK),
      .rst        (RESET),
      .run        (output_enable_reg),
      .count      (count),
      .period_end (period_end)
   );

   sample_assembler u_assemble (
      .res        (res),
      .high_nib   (active_high_reg),
      .low_nib    (active_low_reg),
      .extra_nib  (active_extra_reg),
      .negative   (negative),
      .magnitude  (magnitude)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Differential pins: the sign picks which leg pulses; the other stays low.
   // Pulse width is in clock counts, so long magnitudes clip at the period.
   // The pin enable is registered with the legs but follows HALT_EXEC directly, so on halt it drops one edge before the legs go low.
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         SPEAKER_OUT_POSITIVE <= 1'b0;
         SPEAKER_OUT_NEGATIVE <= 1'b0;
         SPEAKER_OE           <= 1'b1;
      end else begin
         SPEAKER_OE <= !(HALT_EXEC || (halted_reg && !wr_control));
         if (!output_enable_reg || options_reg[`BIT_OPT_DAC]) begin
            SPEAKER_OUT_POSITIVE <= 1'b0;
            SPEAKER_OUT_NEGATIVE <= 1'b0;
         end else begin
            SPEAKER_OUT_POSITIVE <= !negative && leg_on;
            SPEAKER_OUT_NEGATIVE <= negative && leg_on;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // DAC mode: the same sample registers feed a parallel converter code
   // The code reads zero while inactive so a stale sample is never shown
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         DAC_VALID <= 1'b0;
         DAC_CODE  <= 12'h000;
      end else begin
         DAC_VALID <= dac_active;
         if (dac_active) begin
            DAC_CODE <= {negative, magnitude};
         end else begin
            DAC_CODE <= 12'h000;
         end
      end
   end
endmodule : audio_pwm_output

// [rtl/audio_pwm_defines.svh]
// Register offsets, field positions and timing constants of the audio output block
`ifndef AUDIO_PWM_DEFINES_SVH
`define AUDIO_PWM_DEFINES_SVH

`define ADDR_W            8
`define DATA_W            4
`define OFS_STATUS        8'h00
`define OFS_EXTRA_LOW     8'h08
`define OFS_CONTROL       8'h09
`define OFS_LOW           8'h0a
`define OFS_HIGH          8'h0b
`define OFS_OPTIONS       8'h10
`define OFS_IRQ_STATUS    8'h11
`define OFS_IRQ_MASK      8'h12
`define BIT_ZERO_FLAG     0
`define BIT_CARRY_FLAG    1
`define BIT_REQUEST_FLAG  2
`define BIT_OUTPUT_ENABLE 0
`define BIT_GLOBAL_IE     1
`define BIT_OPT_TEN       0
`define BIT_OPT_TWELVE    1
`define BIT_OPT_DAC       2
`define IRQ_BIT_REQUEST   0
`define IRQ_BIT_ACCEPT    1
`define CLK_HZ            50000000
`define SAMPLE_HZ         32000
`define PERIOD_CYCLES     (`CLK_HZ / `SAMPLE_HZ)
`define PERIOD_W          11
`define NIBBLE_ZERO       4'h0

`endif

// [rtl/audio_pwm_pkg.sv]
// Types shared by the audio output block
package audio_pwm_pkg;
   typedef enum logic [2:0] {
      RES_8  = 3'b001,
      RES_10 = 3'b010,
      RES_12 = 3'b100
   } resolution_e;
   typedef logic [11:0] sample_t;
endpackage : audio_pwm_pkg

// [rtl/sample_assembler.sv]
// Builds a signed-magnitude sample from the three data nibbles
`timescale 1ns/1ps
`include "audio_pwm_defines.svh"

module sample_assembler (
   // Mode
   input  wire audio_pwm_pkg::resolution_e res,
   // Data nibbles
   input  wire logic [3:0]                 high_nib,
   input  wire logic [3:0]                 low_nib,
   input  wire logic [3:0]                 extra_nib,
   // Result
   output logic                            negative,
   output logic [10:0]                     magnitude
);
   ////////////////////////////////////////////////////////////////////////////////
   // Sign is always the top bit of the high nibble; the rest is the magnitude
   always_comb begin
      negative = high_nib[3];
      case (res)
         audio_pwm_pkg::RES_12: begin
            magnitude = {high_nib[2:0], low_nib, extra_nib};
         end
         audio_pwm_pkg::RES_10: begin
            magnitude = {2'b00, high_nib[2:0], low_nib, extra_nib[3:2]};
         end
         default: begin
            magnitude = {4'h0, high_nib[2:0], low_nib};
         end
      endcase
   end
endmodule : sample_assembler

// [rtl/period_timer.sv]
// Sample period counter, running only while enabled, with end-of-period pulse
`timescale 1ns/1ps
`include "audio_pwm_defines.svh"

module period_timer (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst,
   // Control
   input  wire logic                  run,
   // Status
   output logic [`PERIOD_W-1:0]       count,
   output logic                       period_end
);
   localparam logic [`PERIOD_W-1:0] LAST = `PERIOD_W'(`PERIOD_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////////////////
   // Counter restarts while stopped so the first period after enable is whole
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count <= '0;
      end else if (!run || count == LAST) begin
         count <= '0;
      end else begin
         count <= count + 1'b1;
      end
   end

   assign period_end = run && (count == LAST);
endmodule : period_timer

// [bench/audio_pwm_checker_assertions.sv]
// Port-level concurrent checks for the audio output block
`timescale 1ns/1ps
`include "audio_pwm_defines.svh"

module audio_pwm_checker (
   // Clock and reset
   input wire logic               CORE_CLK,
   input wire logic               RESET,
   // Register port
   input wire logic [`ADDR_W-1:0] ADDR,
   input wire logic [`DATA_W-1:0] WDATA,
   input wire logic               WR,
   input wire logic               RD,
   input wire logic [`DATA_W-1:0] RDATA,
   // Core events
   input wire logic               HALT_EXEC,
   input wire logic               CARRY_IN,
   input wire logic               ZERO_IN,
   // Speaker and DAC
   input wire logic               SPEAKER_OUT_POSITIVE,
   input wire logic               SPEAKER_OUT_NEGATIVE,
   input wire logic               SPEAKER_OE,
   input wire logic               DAC_VALID,
   input wire logic [11:0]        DAC_CODE,
   // Interrupt
   input wire logic               INT_ACCEPT,
   input wire logic               IRQ
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RESET);
   // Software re-arming the global enable
   wire ie_wr = WR && (ADDR == `OFS_CONTROL) && WDATA[`BIT_GLOBAL_IE];
   wire wo_rd = RD && (ADDR == `OFS_LOW || ADDR == `OFS_HIGH || ADDR == `OFS_EXTRA_LOW);

   ////////////////////////////////////////////////////////////////////////////
   sequence s_accept; INT_ACCEPT; endsequence
   sequence s_quiet; !ie_wr [*4]; endsequence
   property p_int_pulse; s_accept |=> !INT_ACCEPT; endproperty
   a_int_pulse: assert property (p_int_pulse) else $error("accept longer than one cycle");
   // Once taken the enable is gone, so no second accept without re-arming
   property p_int_once; s_accept ##1 s_quiet |=> !INT_ACCEPT; endproperty
   a_int_once: assert property (p_int_once) else $error("accept repeated");
   property p_halt_float; HALT_EXEC |=> !SPEAKER_OE; endproperty
   a_halt_float: assert property (p_halt_float) else $error("pins driven after halt");
   property p_halt_quiet;
      HALT_EXEC |=> ##2 !(SPEAKER_OUT_POSITIVE || SPEAKER_OUT_NEGATIVE);
   endproperty
   a_halt_quiet: assert property (p_halt_quiet) else $error("legs active after halt");
   // Sign picks at most one leg
   property p_legs_excl; !(SPEAKER_OUT_POSITIVE && SPEAKER_OUT_NEGATIVE); endproperty
   a_legs_excl: assert property (p_legs_excl) else $error("both legs high");
   property p_dac_hold; $changed(DAC_CODE) |=> $stable(DAC_CODE) [*8]; endproperty
   a_dac_hold: assert property (p_dac_hold) else $error("code reloaded early");
   property p_status_rd;
      RD && ADDR == `OFS_STATUS |=> RDATA[1:0] == $past({CARRY_IN, ZERO_IN});
   endproperty
   a_status_rd: assert property (p_status_rd) else $error("status flags wrong");
   property p_wo_rd; wo_rd |=> RDATA == `NIBBLE_ZERO; endproperty
   a_wo_rd: assert property (p_wo_rd) else $error("sample register readable");
endmodule : audio_pwm_checker

bind audio_pwm_output audio_pwm_checker u_chk (
   .CORE_CLK(CORE_CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
   .RDATA(RDATA), .HALT_EXEC(HALT_EXEC), .CARRY_IN(CARRY_IN), .ZERO_IN(ZERO_IN),
   .SPEAKER_OUT_POSITIVE(SPEAKER_OUT_POSITIVE), .SPEAKER_OUT_NEGATIVE(SPEAKER_OUT_NEGATIVE),
   .SPEAKER_OE(SPEAKER_OE), .DAC_VALID(DAC_VALID), .DAC_CODE(DAC_CODE),
   .INT_ACCEPT(INT_ACCEPT), .IRQ(IRQ));

// [bench/speaker_model.sv]
// Speaker load that times the drive pulses on each leg
`timescale 1ns/1ps

module speaker_model (
   // Clock and reset
   input  wire logic  clk,
   input  wire logic  rst,
   // Speaker legs
   input  wire logic  pos,
   input  wire logic  neg,
   input  wire logic  oe,
   // Measurement
   input  wire logic  clr,
   output logic [11:0] pos_run,
   output logic [11:0] neg_run,
   output logic [11:0] hi_seen
);
   logic [11:0] pos_cnt;
   logic [11:0] neg_cnt;

   // A floating leg moves no current, so only driven highs are timed
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pos_cnt <= 12'h000;
         neg_cnt <= 12'h000;
         pos_run <= 12'h000;
         neg_run <= 12'h000;
         hi_seen <= 12'h000;
      end else begin
         pos_cnt <= (oe && pos) ? pos_cnt + 12'h001 : 12'h000;
         neg_cnt <= (oe && neg) ? neg_cnt + 12'h001 : 12'h000;
         if (pos_cnt != 12'h000 && !(oe && pos)) pos_run <= pos_cnt;
         if (neg_cnt != 12'h000 && !(oe && neg)) neg_run <= neg_cnt;
         if (clr) hi_seen <= 12'h000;
         else if (oe && (pos || neg)) hi_seen <= hi_seen + 12'h001;
      end
   end
endmodule : speaker_model

// [bench/signed_audio_pwm_dac_output_bench.sv]
// Register-level tests of the audio output block
`timescale 1ns/1ps
`include "audio_pwm_defines.svh"

module signed_audio_pwm_dac_output_bench;
   logic CORE_CLK, RESET, WR, RD, HALT_EXEC, CARRY_IN, ZERO_IN, clr;
   logic [7:0] ADDR;
   logic [3:0] WDATA;
   wire [3:0] RDATA;
   wire [11:0] DAC_CODE, pos_run, neg_run, hi_seen;
   wire POS, NEG, OE, DAC_VALID, INT_ACCEPT, IRQ;
   int n_fail, cmp_count, m;
   // Option codes and expected codes per resolution
   logic [3:0] opt [4] = '{4'h4, 4'h5, 4'h6, 4'h7};
   logic [11:0] e1 [4] = '{12'h835, 12'h8D7, 12'hB5C, 12'hB5C};
   logic [11:0] e2 [4] = '{12'h07F, 12'h1FF, 12'h7FF, 12'h7FF};

   audio_pwm_output uut (.CORE_CLK(CORE_CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
      .WR(WR), .RD(RD), .RDATA(RDATA), .HALT_EXEC(HALT_EXEC), .CARRY_IN(CARRY_IN),
      .ZERO_IN(ZERO_IN), .SPEAKER_OUT_POSITIVE(POS), .SPEAKER_OUT_NEGATIVE(NEG),
      .SPEAKER_OE(OE), .DAC_VALID(DAC_VALID), .DAC_CODE(DAC_CODE),
      .INT_ACCEPT(INT_ACCEPT), .IRQ(IRQ));
   speaker_model u_spk (.clk(CORE_CLK), .rst(RESET), .pos(POS), .neg(NEG), .oe(OE),
      .clr(clr), .pos_run(pos_run), .neg_run(neg_run), .hi_seen(hi_seen));

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge CORE_CLK);
   endtask : tick
   // Gap cycle after each strobe keeps drivers to one assignment per step
   task automatic wr(input logic [7:0] a, input logic [3:0] d);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      tick(1);
      WR <= 1'b0;
      tick(1);
   endtask : wr
   task automatic rdchk(input logic [7:0] a, input logic [3:0] e);
      ADDR <= a;
      RD <= 1'b1;
      tick(1);
      RD <= 1'b0;
      #1;
      chk("rdata", {8'h00, e}, {8'h00, RDATA});
      tick(1);
   endtask : rdchk
   task automatic set_sample(input logic [3:0] h, input logic [3:0] l, input logic [3:0] x);
      wr(`OFS_EXTRA_LOW, x);
      wr(`OFS_LOW, l);
      wr(`OFS_HIGH, h);
   endtask : set_sample
   task automatic clear_req;
      wr(`OFS_IRQ_STATUS, 4'h3);
      wr(`OFS_STATUS, 4'h0);
   endtask : clear_req
   // Bounded wait on IRQ (sel 0) or the accept pulse (sel 1)
   task automatic wait_sig(input int sel);
      logic s;
      s = 1'b0;
      for (int i = 0; i < 2000 && s !== 1'b1; i++) begin
         @(posedge CORE_CLK);
         #1;
         s = sel ? INT_ACCEPT : IRQ;
      end
      chk("wait", 12'h001, {11'h000, s});
   endtask : wait_sig
   task automatic wrap_up;
      $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : wrap_up

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      CORE_CLK = 1'b0;
      forever #10 CORE_CLK = ~CORE_CLK;
   end
   // Three periods per mode plus the speaker runs fit well inside this
   initial begin
      repeat (60000) @(posedge CORE_CLK);
      n_fail++;
      wrap_up;
   end
   initial begin
      {RESET, WR, RD, HALT_EXEC, CARRY_IN, ZERO_IN, clr} = 7'b1000000;
      ADDR = 8'h00;
      WDATA = 4'h0;
      tick(6);
      RESET <= 1'b0;
      CARRY_IN <= 1'b1;
      tick(2);
      rdchk(`OFS_STATUS, 4'h2);
      rdchk(`OFS_CONTROL, 4'h0);
      rdchk(`OFS_HIGH, 4'h0);
      rdchk(8'h1f, 4'h0);
      wr(`OFS_IRQ_MASK, 4'h1);
      // Converter mode over every resolution option
      for (m = 0; m < 4; m++) begin
         wr(`OFS_OPTIONS, opt[m]);
         set_sample(4'hb, 4'h5, 4'hc);
         wr(`OFS_CONTROL, 4'h1);
         wait_sig(0);
         tick(2);
         chk("dac", e1[m], DAC_CODE);
         chk("dac_valid", 12'h001, {11'h000, DAC_VALID});
         rdchk(`OFS_STATUS, 4'h6);
         set_sample(4'h7, 4'hf, 4'hf);
         chk("hold", e1[m], DAC_CODE);
         clear_req;
         wait_sig(0);
         tick(2);
         chk("dac", e2[m], DAC_CODE);
         clear_req;
         wait_sig(0);
         tick(2);
         chk("reuse", e2[m], DAC_CODE);
         clear_req;
         wr(`OFS_CONTROL, 4'h0);
      end
      // Speaker legs in 8-bit PWM, positive then negative sample
      wr(`OFS_OPTIONS, 4'h0);
      for (m = 0; m < 2; m++) begin
         set_sample(m ? 4'h9 : 4'h1, 4'h4, 4'h0);
         wr(`OFS_CONTROL, 4'h1);
         wait_sig(0);
         clear_req;
         wait_sig(0);
         clear_req;
         chk("leg", 12'h014, m ? neg_run : pos_run);
      end
      wr(`OFS_CONTROL, 4'h0);
      tick(3);
      clr <= 1'b1;
      tick(1);
      clr <= 1'b0;
      tick(1600);
      chk("quiet", 12'h000, hi_seen);
      chk("oe", 12'h001, {11'h000, OE});
      // Accept with the request masked from IRQ
      wr(`OFS_IRQ_MASK, 4'h0);
      clear_req;
      wr(`OFS_CONTROL, 4'h3);
      wait_sig(1);
      tick(2);
      chk("irq", 12'h000, {11'h000, IRQ});
      rdchk(`OFS_CONTROL, 4'h1);
      rdchk(`OFS_STATUS, 4'h6);
      wr(`OFS_IRQ_MASK, 4'h1);
      tick(2);
      chk("irq", 12'h001, {11'h000, IRQ});
      clear_req;
      tick(2);
      chk("irq", 12'h000, {11'h000, IRQ});
      HALT_EXEC <= 1'b1;
      tick(1);
      HALT_EXEC <= 1'b0;
      tick(3);
      chk("oe", 12'h000, {11'h000, OE});
      rdchk(`OFS_CONTROL, 4'h0);
      wrap_up;
   end
endmodule : signed_audio_pwm_dac_output_bench
